// File: logic/ssi_absolute_encoder_output.sv
// SSI position output of a singleturn absolute encoder, with direction
// select and zero setting inputs. Assumes the master drives the SSI clock,
// idle high, and that position comes from a sensor on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ssi_absolute_encoder_output
   import ssi_enc_pkg::*;
#(
   parameter int    WIDTH         = POS_BITS,
   parameter bit    GRAY_OUT      = 1'b0,
   parameter int    ZERO_CYC      = ZERO_PULSE_CYC,
   parameter int    HOLD_CYC      = RECOVERY_HOLD_CYC
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] raw_position,
   input  wire logic             ssi_clock,
   input  wire logic             count_dir,
   input  wire logic             zero_set,
   output logic                  ssi_data,
   output logic                  busy
);

   // Counters must hold both long figures; the shift register needs
   // at least two bits and the partner side reads no more than 32
   initial begin
      if (WIDTH < 2 || WIDTH > 32 || ZERO_CYC < 1 || HOLD_CYC < 1 ||
          ZERO_CYC >= (1 << CNT_W) || HOLD_CYC >= (1 << CNT_W)) begin
         $error("ssi_absolute_encoder_output: unsupported parameters");
      end
   end

   // Idle waits for a fall, shift follows the burst, hold is recovery
   typedef enum logic [1:0] {IDLE, SHIFT, HOLD} state_t;

   // Gray variant: adjacent positions differ in one bit only, so a word
   // latched mid-step is off by at most one count
   function automatic logic [WIDTH-1:0] bin2gray(input logic [WIDTH-1:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction : bin2gray

   // Two-stage synchronisers for the pins
   logic [1:0]       clk_sync_q, clk_sync_d;
   logic [1:0]       dir_sync_q, dir_sync_d;
   logic [1:0]       zero_sync_q, zero_sync_d;
   logic             clk_prev_q, clk_prev_d;
   logic             zero_prev_q, zero_prev_d;

   always_comb begin
      clk_sync_d  = {clk_sync_q[0], ssi_clock};
      dir_sync_d  = {dir_sync_q[0], count_dir};
      zero_sync_d = {zero_sync_q[0], zero_set};
      clk_prev_d  = clk_sync_q[1];
      zero_prev_d = zero_sync_q[1];
   end

   // Synchroniser registers reset to the idle pin levels, so
   // no false clock edge or zero release follows reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         clk_sync_q  <= 2'b11;
         dir_sync_q  <= 2'b00;
         zero_sync_q <= 2'b00;
         clk_prev_q  <= 1'b1;
         zero_prev_q <= 1'b0;
      end else begin
         clk_sync_q  <= clk_sync_d;
         dir_sync_q  <= dir_sync_d;
         zero_sync_q <= zero_sync_d;
         clk_prev_q  <= clk_prev_d;
         zero_prev_q <= zero_prev_d;
      end
   end

   // Link clock edges, found only on the second synchroniser stage;
   // each edge is seen two system clocks after the pin moves
   logic clk_fall;
   logic clk_rise;
   assign clk_fall = clk_prev_q & ~clk_sync_q[1];
   assign clk_rise = ~clk_prev_q & clk_sync_q[1];

   // Direction-adjusted position; the sine/cosine track is outside this block
   logic [WIDTH-1:0] dir_pos;
   logic [WIDTH-1:0] rel_pos;
   logic [WIDTH-1:0] offset_q, offset_d;
   logic [CNT_W-1:0] zcnt_q, zcnt_d;

   always_comb begin
      // Two's-complement negation reverses counting sense
      dir_pos = dir_sync_q[1] ? (~raw_position + WIDTH'(1))
                              : raw_position;
      rel_pos = dir_pos - offset_q;
   end

   // Zero setting: pulse counted while high, acted on at release so a
   // stuck-high input never zeroes
   always_comb begin
      zcnt_d   = zcnt_q;
      offset_d = offset_q;
      if (zero_sync_q[1]) begin
         if (zcnt_q != CNT_W'(ZERO_CYC)) begin
            zcnt_d = zcnt_q + CNT_W'(1);
         end
      end else begin
         zcnt_d = '0;
         if (zero_prev_q && zcnt_q == CNT_W'(ZERO_CYC)) begin
            offset_d = dir_pos;
         end
      end
   end

   // Zero offset and pulse length registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         zcnt_q   <= '0;
         offset_q <= WIDTH'(OFFSET_RESET);
      end else begin
         zcnt_q   <= zcnt_d;
         offset_q <= offset_d;
      end
   end

   // Transfer state machine. The burst end is known only once the
   // link clock has stood high for the hold count, so the master's
   // half period must stay shorter than that count; recovery is
   // timed from that point on
   state_t           state_q, state_d;
   logic [WIDTH-1:0] shreg_q, shreg_d;
   logic             data_q, data_d;
   logic [CNT_W-1:0] hold_q, hold_d;

   always_comb begin
      state_d = state_q;
      shreg_d = shreg_q;
      data_d  = data_q;
      hold_d  = hold_q;
      case (state_q)
         IDLE: begin
            data_d = 1'b1;
            if (clk_fall) begin
               // Word fixed at the first falling edge
               shreg_d = GRAY_OUT ? bin2gray(rel_pos) : rel_pos;
               state_d = SHIFT;
            end
         end
         SHIFT: begin
            if (clk_rise) begin
               data_d  = shreg_q[WIDTH-1];
               shreg_d = {shreg_q[WIDTH-2:0], 1'b0};
               hold_d  = '0;
            end else if (clk_sync_q[1]) begin
               // Clock parked high: the last rising edge ended the burst
               hold_d = hold_q + CNT_W'(1);
               if (hold_q == CNT_W'(HOLD_CYC - 1)) begin
                  state_d = HOLD;
                  hold_d  = '0;
               end
            end else begin
               hold_d = '0;
            end
         end
         HOLD: begin
            // Line low through recovery; falling edges ignored
            data_d = 1'b0;
            hold_d = hold_q + CNT_W'(1);
            if (hold_q == CNT_W'(HOLD_CYC - 1)) begin
               data_d  = 1'b1;
               state_d = IDLE;
               hold_d  = '0;
            end
         end
         default: begin
            state_d = IDLE;
            data_d  = 1'b1;
         end
      endcase
   end

   // Transfer registers; the data line resets high, as in idle
   // so the master sees a ready line straight after reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= IDLE;
         shreg_q <= WIDTH'(POS_RESET);
         data_q  <= 1'b1;
         hold_q  <= '0;
      end else begin
         state_q <= state_d;
         shreg_q <= shreg_d;
         data_q  <= data_d;
         hold_q  <= hold_d;
      end
   end

   // Data straight from a flop; busy is a decode of the state,
   // high from the latch until recovery has expired
   assign ssi_data = data_q;
   assign busy     = (state_q != IDLE);

endmodule : ssi_absolute_encoder_output
`default_nettype wire

// File: logic/ssi_enc_pkg.sv
// Package for the SSI absolute position output block.
// Assumes a 40 MHz system clock; all counts derive from it.
package ssi_enc_pkg;
   localparam int          CLK_HZ              = 40_000_000;
   localparam int          POS_BITS            = 25;
   // Minimum zero-setting pulse length, in microseconds
   localparam int          ZERO_PULSE_US       = 100;
   localparam int          ZERO_PULSE_CYC      = (ZERO_PULSE_US * (CLK_HZ / 1_000_000));
   // Typical recovery hold time after a burst, in microseconds
   localparam int          RECOVERY_HOLD_US    = 12;
   localparam int          RECOVERY_HOLD_CYC   = (RECOVERY_HOLD_US * (CLK_HZ / 1_000_000));
   localparam int          CNT_W               = 16;
   localparam logic [24:0] POS_RESET           = 25'h0000000;
   localparam logic [24:0] OFFSET_RESET        = 25'h0000000;
endpackage : ssi_enc_pkg

// File: tb/ssi_out_assertions.sv
// Assertion checker for the SSI output block
// Sees only the block ports; bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module ssi_out_chk #(parameter int HOLD_CYC = 16) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ssi_clock,
   input wire logic zero_set,
   input wire logic ssi_data,
   input wire logic busy
);
   int hi_q;
   int hi_d;
   // Link clock high time, saturating so idle cannot wrap
   always_comb hi_d = !ssi_clock ? 0 : (hi_q < 999 ? hi_q + 1 : hi_q);
   always_ff @(posedge clk) hi_q <= hi_d;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_idle; !busy && !$past(busy) |-> ssi_data; endproperty
   a_idle: assert property (p_idle) else $error("data low in idle");
   property p_latch; $fell(ssi_clock) && !busy |-> ##[1:5] busy; endproperty
   a_latch: assert property (p_latch) else $error("no latch");
   property p_latch_low; $rose(busy) |-> hi_q == 0; endproperty
   a_latch_low: assert property (p_latch_low) else $error("latch off edge");
   property p_stay; busy && hi_q < HOLD_CYC |=> busy; endproperty
   a_stay: assert property (p_stay) else $error("early end");
   property p_shift; busy && $changed(ssi_data) && hi_q < HOLD_CYC |-> hi_q inside {[1:6]};
   endproperty
   a_shift: assert property (p_shift) else $error("bit off rise");
   property p_rec_low; busy && hi_q == HOLD_CYC + 6 |-> !ssi_data; endproperty
   a_rec_low: assert property (p_rec_low) else $error("data high in hold");
   property p_ready; hi_q == 2 * HOLD_CYC + 10 |-> !busy && ssi_data; endproperty
   a_ready: assert property (p_ready) else $error("not ready");
   property p_rst; $rose(rst_b) |-> ssi_data && !busy; endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   c_latch: cover property ($rose(busy));
   c_hold: cover property (busy && hi_q == HOLD_CYC + 6);
   c_zero: cover property ($fell(zero_set));
endmodule : ssi_out_chk
bind ssi_absolute_encoder_output ssi_out_chk #(.HOLD_CYC(HOLD_CYC)) chk_u (.clk(clk),
   .rst_b(rst_b), .ssi_clock(ssi_clock), .zero_set(zero_set), .ssi_data(ssi_data), .busy(busy));
`default_nettype wire

// File: tb/ssi_master_model.sv
// SSI master model: makes the link clock and gathers bits
// Assumes the bench clock; link clock stands high between bursts
`timescale 1ns/1ps
`default_nettype none
module ssi_master_model (
   input  wire logic clk,
   input  wire logic ssi_data,
   output var logic  ssi_clock
);
   initial ssi_clock = 1'b1; // Idle high, master owns the clock
   // n rising edges; each bit read just before the next rise
   task automatic burst(input int n, output logic [31:0] word);
      word = '0;
      @(posedge clk);
      #2 ssi_clock = 1'b0;
      for (int k = 0; k < n; k++) begin
         #100;
         if (k > 0) word = {word[30:0], ssi_data};
         ssi_clock = 1'b1;
         if (k < n - 1) #100 ssi_clock = 1'b0;
      end
   endtask : burst
endmodule : ssi_master_model
`default_nettype wire

// File: tb/ssi_absolute_encoder_output_test.sv
// Bench for the SSI output block: random angles, both directions, zero
// Assumes the master model drives the link clock
`timescale 1ns/1ps
`default_nettype none
module ssi_absolute_encoder_output_test;
   logic        clk = 1'b0;
   logic        rst_b, count_dir, zero_set, ssi_clock, ssi_data, busy, gray_data;
   logic [24:0] raw_position, offset_q, lfsr_q;
   logic [31:0] word, gword;
   int          err_total = 0;
   int          cmp_count = 0;
   ssi_absolute_encoder_output #(.ZERO_CYC(20), .HOLD_CYC(16)) dut_u (.clk(clk), .rst_b(rst_b),
      .raw_position(raw_position), .ssi_clock(ssi_clock), .count_dir(count_dir),
      .zero_set(zero_set), .ssi_data(ssi_data), .busy(busy));
   ssi_master_model m_u (.clk(clk), .ssi_data(ssi_data), .ssi_clock(ssi_clock));
   // Gray variant on the same link clock; its own model only gathers bits
   ssi_absolute_encoder_output #(.GRAY_OUT(1'b1), .ZERO_CYC(20), .HOLD_CYC(16)) dut_g (
      .clk(clk), .rst_b(rst_b), .raw_position(raw_position), .ssi_clock(ssi_clock),
      .count_dir(count_dir), .zero_set(zero_set), .ssi_data(gray_data), .busy());
   ssi_master_model g_u (.clk(clk), .ssi_data(gray_data), .ssi_clock());
   initial forever #12.5 clk = ~clk;
   function automatic logic [24:0] lfsr_next(input logic [24:0] s);
      return {s[23:0], s[24] ^ s[21]};
   endfunction : lfsr_next
   function automatic logic [24:0] to_gray(input logic [24:0] b);
      return b ^ (b >> 1);
   endfunction : to_gray
   function automatic logic [24:0] dir_pos(input logic [24:0] p, input logic d);
      return d ? -p : p;
   endfunction : dir_pos
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   // Zero pulse of len cycles; only long ones move the offset
   task automatic zero(input int len);
      zero_set = 1'b1;
      repeat (len) @(posedge clk);
      #2 zero_set = 1'b0;
      if (len >= 24) offset_q = dir_pos(raw_position, count_dir);
      repeat (6) @(posedge clk);
   endtask : zero
   // One burst of n rises; surplus clocks must read zero
   task automatic xfer(input int n);
      logic [24:0] exp;
      exp = dir_pos(raw_position, count_dir) - offset_q;
      fork
         m_u.burst(n, word);
         g_u.burst(n, gword);
      join
      check(word, {exp, 7'h00} >> (33 - n));
      check(gword, {to_gray(exp), 7'h00} >> (33 - n));
      for (int t = 0; busy !== 1'b0; t++) begin
         if (t > 200) begin
            err_total++;
            print_verdict();
         end
         @(posedge clk);
      end
      check({31'h0, ssi_data}, 32'h1);
      repeat (4) @(posedge clk); // Gap well past recovery
      $display("transfer of %0d clocks done", n);
   endtask : xfer
   initial begin
      rst_b = 1'b0;
      count_dir = 1'b0;
      zero_set = 1'b0;
      offset_q = '0;
      lfsr_q = 25'h000001c;
      raw_position = lfsr_q;
      repeat (10) @(posedge clk);
      #2 rst_b = 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         #2 raw_position = lfsr_q;
         count_dir = i > 3;
         if (i == 1 || i == 4) zero(24); // Zero after direction settles
         if (i == 3) zero(12);
         xfer(26 + i % 3);
      end
      print_verdict();
   end
endmodule : ssi_absolute_encoder_output_test
`default_nettype wire
